/* logic/erd_pkg.sv */
// ****************************************************************
// Receive descriptor DMA constants and types
// ****************************************************************
package erd_pkg;

   // Ownership codes in descriptor word 0
   localparam logic [1:0] OWN_CPU = 2'h0;
   localparam logic [1:0] OWN_MAC = 2'h2;
   localparam logic [1:0] OWN_XLATE = 2'h3;

   // Status word field positions
   localparam int OWN_HI = 31;
   localparam int OWN_LO = 30;
   localparam int RSVD_HI = 29;
   localparam int RSVD_LO = 23;
   localparam int RUNT_BIT = 22;
   localparam int ALIGN_BIT = 21;
   localparam int DONE_BIT = 20;
   localparam int LONG_BIT = 19;
   localparam int RSVD18_BIT = 18;
   localparam int FCS_BIT = 17;
   localparam int IRQ_BIT = 16;
   localparam int LEN_W = 16;

   // Descriptor word byte offsets; word 2 is never read
   localparam logic [31:0] W0_OFS = 32'h0000_0000;
   localparam logic [31:0] W1_OFS = 32'h0000_0004;
   localparam logic [31:0] W3_OFS = 32'h0000_000C;

   // Frame length limits in bytes
   localparam logic [15:0] MIN_FRAME = 16'h0040;
   localparam logic [15:0] MAX_FRAME = 16'h05EE;
   localparam logic [15:0] FCS_BYTES = 16'h0004;
   localparam logic [15:0] LEN_MAX = 16'hFFFF;

   // Receive FIFO size in bytes
   localparam int FIFO_BYTES = 256;

   // Line code: start-of-frame dibit, reflected CRC
   localparam logic [1:0] DIBIT_SFD = 2'h3;
   localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
   localparam logic [31:0] CRC_GOOD = 32'hDEBB_20E3;

   // One byte through the FIFO; last marks the end entry
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } erd_byte_s;

   // One memory request of the DMA master
   typedef struct packed {
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } erd_mem_req_s;

   // DMA states, Gray in the order listed
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_FETCH0 = 3'h1,
      ST_FETCH1 = 3'h3,
      ST_FETCH3 = 3'h2,
      ST_RECV = 3'h6,
      ST_STORE = 3'h7,
      ST_WBACK = 3'h5,
      ST_HALT = 3'h4
   } erd_state_e;

endpackage : erd_pkg

/* logic/erd_fifo.sv */
`timescale 1ns/100ps
// ****************************************************************
// Byte FIFO with registered read data
// ****************************************************************
module erd_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 256
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Fill side
   input wire logic i_wr_valid,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_wr_ready,
   // Drain side
   output logic o_rd_valid,
   output logic [WIDTH-1:0] o_rd_data,
   input wire logic i_rd_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wptr_ff;
   logic [AW-1:0] rptr_ff;
   logic [AW:0] count_ff;
   logic rd_valid_ff;
   logic [WIDTH-1:0] rd_data_ff;

   // Handshake decode
   wire push_w = i_wr_valid && o_wr_ready;
   wire load_w = (count_ff != '0) && (!rd_valid_ff || i_rd_ready);
   assign o_wr_ready = count_ff != (AW + 1)'(DEPTH);
   assign o_rd_valid = rd_valid_ff;
   assign o_rd_data = rd_data_ff;

   // Storage array
   always_ff @(posedge i_mclk) begin
      if (push_w) begin
         mem_ff[wptr_ff] <= i_wr_data;
      end
   end

   // Pointers, fill count and output register
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         count_ff <= '0;
         rd_valid_ff <= 1'b0;
         rd_data_ff <= '0;
      end else begin
         wptr_ff <= push_w ? wptr_ff + 1'b1 : wptr_ff;
         rptr_ff <= load_w ? rptr_ff + 1'b1 : rptr_ff;
         count_ff <= count_ff + (AW + 1)'(push_w) - (AW + 1)'(load_w);
         if (load_w) begin
            rd_data_ff <= mem_ff[rptr_ff];
            rd_valid_ff <= 1'b1;
         end else if (i_rd_ready) begin
            rd_valid_ff <= 1'b0;
         end
      end
   end

   a_fifo_bound: assert property (@(posedge i_mclk) disable iff (i_reset) // R20
      count_ff <= (AW + 1)'(DEPTH)) else $error("fifo count above depth");
   a_fifo_full_stall: assert property (@(posedge i_mclk) disable iff (i_reset) // R20
      (count_ff == (AW + 1)'(DEPTH)) && !load_w |=> $stable(count_ff)) else $error("fifo grew while full");

endmodule : erd_fifo

/* logic/erd_rmii_rx.sv */
`timescale 1ns/100ps
// ****************************************************************
// Reduced media-independent receive front end
// ****************************************************************
module erd_rmii_rx (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Line pins
   input wire logic i_ref_clk,
   input wire logic i_crs_dv,
   input wire logic [1:0] i_rxd,
   // Byte stream out
   input wire logic i_ready,
   output logic o_valid,
   output erd_pkg::erd_byte_s o_byte
);
   logic [2:0] ref_sync_ff;
   logic [1:0] crs_sync_ff;
   logic [1:0] rxd_s1_ff;
   logic [1:0] rxd_s2_ff;
   logic in_frame_ff;
   logic [1:0] phase_ff;
   logic [5:0] shift_ff;
   logic [31:0] crc_ff;
   logic ovf_ff;
   logic valid_ff;
   erd_pkg::erd_byte_s byte_ff;

   // Bitwise reflected CRC over one byte
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ erd_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_byte

   // Line sampling decode
   wire fall_w = !ref_sync_ff[1] && ref_sync_ff[2];
   wire [7:0] new_byte_w = {rxd_s2_ff, shift_ff};
   wire byte_done_w = fall_w && crs_sync_ff[1] && in_frame_ff && (phase_ff == 2'h3);
   wire frame_end_w = fall_w && !crs_sync_ff[1] && in_frame_ff;
   wire fcs_bad_w = (crc_ff != erd_pkg::CRC_GOOD) || ovf_ff;
   wire align_bad_w = phase_ff != 2'h0;
   assign o_valid = valid_ff;
   assign o_byte = byte_ff;

   // Two-stage synchronisers on every line pin
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         ref_sync_ff <= 3'h0;
         crs_sync_ff <= 2'h0;
         rxd_s1_ff <= 2'h0;
         rxd_s2_ff <= 2'h0;
      end else begin
         ref_sync_ff <= {ref_sync_ff[1:0], i_ref_clk}; // R19
         crs_sync_ff <= {crs_sync_ff[0], i_crs_dv};
         rxd_s1_ff <= i_rxd;
         rxd_s2_ff <= rxd_s1_ff;
      end
   end

   // Dibit assembly on falling reference edge, no length filter
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         in_frame_ff <= 1'b0;
         phase_ff <= 2'h0;
         shift_ff <= 6'h0;
         crc_ff <= erd_pkg::CRC_INIT;
         ovf_ff <= 1'b0;
         valid_ff <= 1'b0;
         byte_ff <= '0;
      end else begin
         valid_ff <= 1'b0;
         if (frame_end_w) begin
            in_frame_ff <= 1'b0;
            valid_ff <= i_ready;
            byte_ff <= '{last: 1'b1, data: {6'h0, align_bad_w, fcs_bad_w}}; // R7 R10
         end else if (fall_w && crs_sync_ff[1] && !in_frame_ff) begin
            in_frame_ff <= rxd_s2_ff == erd_pkg::DIBIT_SFD;
            phase_ff <= 2'h0;
            crc_ff <= erd_pkg::CRC_INIT;
            ovf_ff <= 1'b0;
         end else if (fall_w && crs_sync_ff[1]) begin
            phase_ff <= phase_ff + 2'h1;
            shift_ff <= {rxd_s2_ff, shift_ff[5:2]};
            if (byte_done_w) begin
               crc_ff <= crc_byte(crc_ff, new_byte_w); // R10
               valid_ff <= i_ready; // R21
               ovf_ff <= ovf_ff || !i_ready;
               byte_ff <= '{last: 1'b0, data: new_byte_w};
            end
         end
      end
   end

   a_marker_align: assert property (@(posedge i_mclk) disable iff (i_reset) // R7
      frame_end_w && i_ready |=> o_valid && o_byte.last && (o_byte.data[1] == $past(align_bad_w)))
      else $error("end marker alignment flag wrong");

endmodule : erd_rmii_rx

/* logic/erd_rx_dma.sv */
`timescale 1ns/100ps
// Behaviour
// R1: Descriptor bits 31:30 hold owner; 00 is CPU, 10 is the receive DMA.
// R2: Only the owner modifies a descriptor; the DMA stores only into its own.
// R3: On frame end the DMA writes owner 11 if translation needed, else 00.
// R4: Software writes owner 10 after processing to hand the descriptor back.
// R5: The DMA alone writes status; bits 29 to 23 are reserved, written zero.
// R6: Runt flag bit 22 is set for frames under 64 bytes, clear otherwise.
// R7: Alignment flag bit 21 is set for frames not a whole number of bytes.
// R8: Reception-complete flag bit 20 is set once the frame is fully stored.
// R9: Too-long flag bit 19 is set for frames over 1518 bytes.
// R10: FCS error flag bit 17 is set when the frame check sequence failed.
// R11: Interrupt flag bit 16 is set when the frame raised an interrupt condition.
// R12: Bits 15:0 carry the frame length, including four FCS bytes by default.
// R13: With FCS stripping enabled the four FCS bytes leave the reported count.
// R14: Word 1 bits 31:2 give the word-aligned buffer base.
// R15: Word 1 bits 1:0 give a byte offset added to the buffer base.
// R16: Word 2 is obsolete; the DMA never depends on it.
// R17: Word 3 is the next descriptor address; its two low bits are ignored.
// R18: Each descriptor is four consecutive words linked into a list.
// R19: The line side is a reduced media-independent interface on a reference clock.
// R20: Received data pass a 256-byte FIFO between line and DMA.
// R21: Over-long and runt frames are stored and flagged, never dropped.
// R22: After write-back the DMA fetches the next descriptor from the stored link.
// R23: A descriptor not owned by the DMA halts storing until software resumes.
module erd_rx_dma #(
   parameter int FIFO_DEPTH = erd_pkg::FIFO_BYTES
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Line pins
   input wire logic i_ref_clk,
   input wire logic i_crs_dv,
   input wire logic [1:0] i_rxd,
   // Control
   input wire logic i_rx_enable,
   input wire logic [31:0] i_start_desc,
   input wire logic i_strip_fcs_enable,
   input wire logic i_frame_irq_enable,
   input wire logic i_xlate_needed,
   input wire logic i_resume,
   // Memory master
   output logic o_mem_req,
   output erd_pkg::erd_mem_req_s o_mem,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata,
   // Status
   output logic o_halted,
   output logic o_frame_done,
   output logic [31:0] o_desc_addr
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   erd_pkg::erd_state_e state_ff;
   erd_pkg::erd_state_e nxt_state;
   erd_pkg::erd_mem_req_s mem_ff;
   erd_pkg::erd_mem_req_s nxt_mem;
   logic mem_req_ff;
   logic nxt_req;
   logic [31:0] desc_ff;
   logic [31:0] buf_addr_ff;
   logic [31:0] next_ff;
   logic [15:0] cnt_ff;
   logic discard_ff;
   logic done_ff;
   logic halted_ff;
   logic strip_ff;
   logic xlate_ff;
   logic irq_ff;
   logic align_ff;
   logic fcs_ff;
   logic rx_valid;
   erd_pkg::erd_byte_s rx_byte;
   logic fifo_wr_ready;
   logic f_valid;
   logic [$bits(erd_pkg::erd_byte_s)-1:0] f_raw;
   erd_pkg::erd_byte_s f_data;
   logic f_ready;

   // Read request for one descriptor word
   function automatic erd_pkg::erd_mem_req_s rd_req(input logic [31:0] a);
      return '{we: 1'b0, addr: a, wdata: 32'h0000_0000, be: 4'hF};
   endfunction : rd_req

   // Byte lane enable from the low address bits
   function automatic logic [3:0] lane_be(input logic [1:0] a);
      return 4'h1 << a;
   endfunction : lane_be

   // ****************************************************************
   // Line front end and FIFO
   // ****************************************************************
   erd_rmii_rx u_line (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_ref_clk(i_ref_clk),
      .i_crs_dv(i_crs_dv),
      .i_rxd(i_rxd),
      .i_ready(fifo_wr_ready),
      .o_valid(rx_valid),
      .o_byte(rx_byte)
   );

   erd_fifo #(
      .WIDTH($bits(erd_pkg::erd_byte_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_wr_valid(rx_valid),
      .i_wr_data(rx_byte),
      .o_wr_ready(fifo_wr_ready),
      .o_rd_valid(f_valid),
      .o_rd_data(f_raw),
      .i_rd_ready(f_ready)
   ); // R20

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire ack_w = mem_req_ff && i_mem_ack;
   wire owned_w = i_mem_rdata[erd_pkg::OWN_HI:erd_pkg::OWN_LO] == erd_pkg::OWN_MAC; // R1
   wire pop_w = f_valid && f_ready;
   wire take_w = pop_w && (state_ff == erd_pkg::ST_RECV) && !discard_ff;
   wire [31:0] byte_addr_w = buf_addr_ff + {16'h0000, cnt_ff}; // R15
   wire runt_w = cnt_ff < erd_pkg::MIN_FRAME; // R6 R21
   wire long_w = cnt_ff > erd_pkg::MAX_FRAME; // R9 R21
   wire strip_now_w = i_strip_fcs_enable && (cnt_ff >= erd_pkg::FCS_BYTES);
   wire [15:0] len_w = strip_now_w ? cnt_ff - erd_pkg::FCS_BYTES : cnt_ff; // R12 R13
   wire [1:0] own_back_w = i_xlate_needed ? erd_pkg::OWN_XLATE : erd_pkg::OWN_CPU; // R3
   wire [31:0] status_w = {own_back_w, 7'h00, runt_w, f_data.data[1], 1'b1, long_w, 1'b0,
      f_data.data[0], i_frame_irq_enable, len_w}; // R5 R7 R8 R10 R11
   wire [7:0] wb_byte_w = f_data.data;
   assign f_data = f_raw;
   assign f_ready = (state_ff == erd_pkg::ST_IDLE) || (state_ff == erd_pkg::ST_HALT)
      || (state_ff == erd_pkg::ST_RECV);
   assign o_mem_req = mem_req_ff;
   assign o_mem = mem_ff;
   assign o_halted = halted_ff;
   assign o_frame_done = done_ff;
   assign o_desc_addr = desc_ff;

   // ****************************************************************
   // Descriptor walk
   // ****************************************************************

   // Next state and next memory request
   always_comb begin
      nxt_state = state_ff;
      nxt_req = mem_req_ff && !i_mem_ack;
      nxt_mem = mem_ff;
      case (state_ff)
         erd_pkg::ST_IDLE: begin
            if (i_rx_enable) begin
               nxt_state = erd_pkg::ST_FETCH0;
               nxt_req = 1'b1;
               nxt_mem = rd_req({i_start_desc[31:2], 2'b00}); // R17
            end
         end
         erd_pkg::ST_FETCH0: begin
            if (ack_w && owned_w) begin
               nxt_state = erd_pkg::ST_FETCH1; // R2
               nxt_req = 1'b1;
               nxt_mem = rd_req(desc_ff + erd_pkg::W1_OFS); // R18
            end else if (ack_w) begin
               nxt_state = erd_pkg::ST_HALT; // R23
            end
         end
         erd_pkg::ST_FETCH1: begin
            if (ack_w) begin
               nxt_state = erd_pkg::ST_FETCH3;
               nxt_req = 1'b1;
               nxt_mem = rd_req(desc_ff + erd_pkg::W3_OFS); // R16 R18
            end
         end
         erd_pkg::ST_FETCH3: begin
            if (ack_w) begin
               nxt_state = erd_pkg::ST_RECV;
            end
         end
         erd_pkg::ST_RECV: begin
            if (take_w && f_data.last) begin
               nxt_state = erd_pkg::ST_WBACK;
               nxt_req = 1'b1;
               nxt_mem = '{we: 1'b1, addr: desc_ff + erd_pkg::W0_OFS, wdata: status_w, be: 4'hF}; // R5
            end else if (take_w) begin
               nxt_state = erd_pkg::ST_STORE;
               nxt_req = 1'b1;
               nxt_mem = '{we: 1'b1, addr: byte_addr_w, wdata: {4{wb_byte_w}},
                  be: lane_be(byte_addr_w[1:0])}; // R14 R15
            end
         end
         erd_pkg::ST_STORE: begin
            if (ack_w) begin
               nxt_state = erd_pkg::ST_RECV;
            end
         end
         erd_pkg::ST_WBACK: begin
            if (ack_w) begin
               nxt_state = erd_pkg::ST_FETCH0; // R22
               nxt_req = 1'b1;
               nxt_mem = rd_req(next_ff);
            end
         end
         erd_pkg::ST_HALT: begin
            if (!i_rx_enable) begin
               nxt_state = erd_pkg::ST_IDLE;
            end else if (i_resume) begin
               nxt_state = erd_pkg::ST_FETCH0; // R4 R23
               nxt_req = 1'b1;
               nxt_mem = rd_req(desc_ff);
            end
         end
         default: begin
            nxt_state = erd_pkg::ST_IDLE;
            nxt_req = 1'b0;
         end
      endcase
   end

   // State and memory request registers
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         state_ff <= erd_pkg::ST_IDLE;
         mem_req_ff <= 1'b0;
         mem_ff <= '0;
         halted_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         mem_req_ff <= nxt_req;
         mem_ff <= nxt_mem;
         halted_ff <= nxt_state == erd_pkg::ST_HALT; // R23
         done_ff <= (state_ff == erd_pkg::ST_WBACK) && ack_w; // R8
      end
   end

   // Descriptor pointers from fetched words
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         desc_ff <= 32'h0000_0000;
         buf_addr_ff <= 32'h0000_0000;
         next_ff <= 32'h0000_0000;
      end else begin
         if ((state_ff == erd_pkg::ST_IDLE) && i_rx_enable) begin
            desc_ff <= {i_start_desc[31:2], 2'b00};
         end else if ((state_ff == erd_pkg::ST_WBACK) && ack_w) begin
            desc_ff <= next_ff; // R22
         end
         if ((state_ff == erd_pkg::ST_FETCH1) && ack_w) begin
            buf_addr_ff <= i_mem_rdata; // R14 R15
         end
         if ((state_ff == erd_pkg::ST_FETCH3) && ack_w) begin
            next_ff <= {i_mem_rdata[31:2], 2'b00}; // R17
         end
      end
   end

   // Byte count, saturating at the field width
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         cnt_ff <= 16'h0000;
      end else if ((state_ff == erd_pkg::ST_FETCH3) && ack_w) begin
         cnt_ff <= 16'h0000;
      end else if ((state_ff == erd_pkg::ST_STORE) && ack_w && (cnt_ff != erd_pkg::LEN_MAX)) begin
         cnt_ff <= cnt_ff + 16'h0001; // R12
      end
   end

   // Drop frames seen while idle or halted, up to their end marker
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         discard_ff <= 1'b0;
      end else if (pop_w && ((state_ff != erd_pkg::ST_RECV) || discard_ff)) begin
         discard_ff <= !f_data.last; // R2
      end
   end

   // Frame-end settings kept for checking the write-back
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         strip_ff <= 1'b0;
         xlate_ff <= 1'b0;
         irq_ff <= 1'b0;
         align_ff <= 1'b0;
         fcs_ff <= 1'b0;
      end else if (take_w && f_data.last) begin
         strip_ff <= i_strip_fcs_enable;
         xlate_ff <= i_xlate_needed;
         irq_ff <= i_frame_irq_enable;
         align_ff <= f_data.data[1];
         fcs_ff <= f_data.data[0];
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   wire wb_w = (state_ff == erd_pkg::ST_WBACK) && mem_req_ff;

   sequence s_fetch_owned;
      (state_ff == erd_pkg::ST_FETCH0) && ack_w && owned_w;
   endsequence

   sequence s_fetch_foreign;
      (state_ff == erd_pkg::ST_FETCH0) && ack_w && !owned_w;
   endsequence

   sequence s_wback_done;
      (state_ff == erd_pkg::ST_WBACK) && ack_w;
   endsequence

   a_foreign_halt: assert property (@(posedge i_mclk) disable iff (i_reset) // R23
      s_fetch_foreign |=> o_halted && !o_mem_req ##1 !(o_mem_req && o_mem.we))
      else $error("foreign descriptor not halted");
   a_owned_walk: assert property (@(posedge i_mclk) disable iff (i_reset) // R18
      s_fetch_owned |=> o_mem_req && !o_mem.we && (o_mem.addr == desc_ff + 32'h0000_0004))
      else $error("word 1 fetch address wrong");
   a_owner_return: assert property (@(posedge i_mclk) disable iff (i_reset) // R3
      wb_w |-> o_mem.wdata[31:30] == (xlate_ff ? 2'b11 : 2'b00))
      else $error("returned owner code wrong");
   a_reserved_zero: assert property (@(posedge i_mclk) disable iff (i_reset) // R5
      wb_w |-> (o_mem.wdata[29:23] == 7'h00) && !o_mem.wdata[18] && (o_mem.be == 4'hF))
      else $error("reserved status bits set");
   a_size_flags: assert property (@(posedge i_mclk) disable iff (i_reset) // R6
      wb_w |-> (o_mem.wdata[22] == (cnt_ff < 16'h0040)) && (o_mem.wdata[19] == (cnt_ff > 16'h05EE)))
      else $error("runt or long flag wrong");
   a_done_flags: assert property (@(posedge i_mclk) disable iff (i_reset) // R8
      wb_w |-> o_mem.wdata[20] && (o_mem.wdata[21] == align_ff) && (o_mem.wdata[17] == fcs_ff)
      && (o_mem.wdata[16] == irq_ff)) else $error("frame end flags wrong");
   a_length_field: assert property (@(posedge i_mclk) disable iff (i_reset) // R13
      wb_w |-> o_mem.wdata[15:0] == ((strip_ff && cnt_ff >= 16'h0004) ? cnt_ff - 16'h0004 : cnt_ff))
      else $error("reported length wrong");
   a_next_fetch: assert property (@(posedge i_mclk) disable iff (i_reset) // R22
      s_wback_done |=> o_mem_req && !o_mem.we && (o_mem.addr == $past(next_ff)) && (o_mem.addr[1:0] == 2'b00)
      ##1 (state_ff == erd_pkg::ST_FETCH0)) else $error("next descriptor not fetched");
   a_store_addr: assert property (@(posedge i_mclk) disable iff (i_reset) // R15
      take_w && !f_data.last |=> o_mem_req && (o_mem.addr == $past(byte_addr_w))
      && (o_mem.be == (4'h1 << o_mem.addr[1:0]))) else $error("byte store address wrong");
   a_store_owned: assert property (@(posedge i_mclk) disable iff (i_reset) // R2
      o_mem_req && o_mem.we |-> (state_ff == erd_pkg::ST_STORE) || (state_ff == erd_pkg::ST_WBACK))
      else $error("write outside an owned descriptor");

endmodule : erd_rx_dma

/* testbench/erd_mem_model.sv */
`timescale 1ns/100ps
// ****************************************************************
// Shared descriptor memory, prompt or slow
// ****************************************************************
module erd_mem_model (
   // Clock, reset, pacing
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_slow,
   // Memory slave
   input wire logic i_mem_req,
   input wire erd_pkg::erd_mem_req_s i_mem,
   output logic o_mem_ack,
   output logic [31:0] o_mem_rdata
);
   logic [31:0] m [0:255];
   logic tick;
   wire take = i_mem_req & ~o_mem_ack & (~i_slow | tick);
   // One ack a request; read data scrambled outside the ack cycle
   always @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_mem_ack <= 1'b0;
         o_mem_rdata <= 32'h0;
         tick <= 1'b0;
      end else begin
         tick <= ~tick;
         o_mem_ack <= take;
         o_mem_rdata <= take ? m[i_mem.addr[9:2]] : ~o_mem_rdata;
      end
   end
   // Byte lanes land when the write completes
   always @(posedge i_mclk) begin
      for (int k = 0; k < 4; k++) begin
         if (i_mem_req & o_mem_ack & i_mem.we & i_mem.be[k]) m[i_mem.addr[9:2]][8*k+:8] <= i_mem.wdata[8*k+:8];
      end
   end
endmodule : erd_mem_model

/* testbench/test_erd_rx_dma.sv */
`timescale 1ns/100ps
// ****************************************************************
// Receive descriptor DMA bench
// ****************************************************************
module test_erd_rx_dma;
   logic clk, rst, refc, dv, en, strip, irq, xl, res, slow, req, ack, halted, done;
   logic [1:0] rxd;
   logic [31:0] sd, rdata, daddr;
   erd_pkg::erd_mem_req_s mem;
   logic [7:0] seed = 8'h08;
   int err_total = 0, n_compared = 0, cyc = 0;
   // Design and shared memory
   erd_rx_dma u_dut (.i_mclk(clk), .i_reset(rst), .i_ref_clk(refc), .i_crs_dv(dv), .i_rxd(rxd), .i_rx_enable(en),
      .i_start_desc(sd), .i_strip_fcs_enable(strip), .i_frame_irq_enable(irq), .i_xlate_needed(xl),
      .i_resume(res), .o_mem_req(req), .o_mem(mem), .i_mem_ack(ack), .i_mem_rdata(rdata), .o_halted(halted),
      .o_frame_done(done), .o_desc_addr(daddr));
   erd_mem_model u_mem (.i_mclk(clk), .i_reset(rst), .i_slow(slow), .i_mem_req(req), .i_mem(mem),
      .o_mem_ack(ack), .o_mem_rdata(rdata));
   // Clocks: 25 ns system, free 200 ns line reference
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      refc = 0;
      forever #100 refc = ~refc;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         tally_and_finish();
      end
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   // One dibit per line reference period
   task automatic dib(input logic v, input logic [1:0] d);
      @(posedge refc);
      @(posedge clk);
      dv <= v;
      rxd <= d;
   endtask : dib
   task automatic wt;
      @(negedge clk);
      for (int t = 0; t < 20000 && done !== 1'b1 && halted !== 1'b1; t++) @(negedge clk);
   endtask : wt
   // Frame s: 0 is 64 bytes good, 1 is 63 bytes bad FCS, stripped, translated
   task automatic frame(input int s);
      int n, len;
      logic [31:0] c, a, w;
      logic [7:0] q[$];
      n = 60 - s;
      c = erd_pkg::CRC_INIT;
      a = s ? 32'h303 : 32'h201;
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         q.push_back(seed);
         for (int j = 0; j < 8; j++) c = (c >> 1) ^ ((c[0] ^ seed[j]) ? erd_pkg::CRC_POLY : 32'h0);
      end
      for (int i = 0; i < 4; i++) q.push_back(~c[8*i+:8] ^ 8'(s));
      repeat (7) dib(1'b1, 2'h1);
      dib(1'b1, 2'h3);
      foreach (q[i]) for (int k = 0; k < 4; k++) dib(1'b1, q[i][2*k+:2]);
      if (s) dib(1'b1, 2'h0);
      dib(1'b0, ~rxd);
      wt();
      chk(done, 1);
      len = n + 4 - (s ? 4 : 0);
      chk(u_mem.m[64+4*s], {s ? 2'h3 : 2'h0, 7'h0, 1'(n + 4 < 64), s[0], 3'h4, s[0], !s[0], len[15:0]});
      for (int i = 0; i < len; i++) begin
         w = u_mem.m[(a+i)>>2] >> (8*((a+i)%4));
         chk(w[7:0], q[i]);
      end
   endtask : frame
   // Main sequence
   initial begin
      {rst, dv, en, res, slow, strip, irq, xl} = 8'h80;
      rxd = 2'h0;
      sd = 32'h100;
      u_mem.m[64] = 32'h8000_0000;
      u_mem.m[65] = 32'h0000_0201;
      u_mem.m[66] = 32'hFFFF_FFFF;
      u_mem.m[67] = 32'h0000_0113;
      u_mem.m[68] = 32'h8000_0000;
      u_mem.m[69] = 32'h0000_0303;
      u_mem.m[71] = 32'h0000_0120;
      u_mem.m[72] = 32'h0;
      u_mem.m[73] = 32'h0000_0380;
      u_mem.m[75] = 32'h0000_0120;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      en <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         strip <= s[0];
         irq <= !s[0];
         xl <= s[0];
         slow <= s[0];
         frame(s);
      end
      wt();
      chk(halted, 1);
      chk(daddr, 32'h120);
      chk(u_mem.m[72], 32'h0);
      u_mem.m[72] = 32'h8000_0000;
      @(posedge clk) res <= 1'b1;
      @(posedge clk) res <= 1'b0;
      for (int t = 0; t < 100 && halted === 1'b1; t++) @(negedge clk);
      chk(halted, 0);
      tally_and_finish();
   end
endmodule : test_erd_rx_dma
